// ===== rtl/tsout_defines.svh
// constants for the transport packet output port
`ifndef TSOUT_DEFINES_SVH
`define TSOUT_DEFINES_SVH
`define CFG_OFFSET       8'h8A
`define CFG_RESET        8'h45
`define CFG_BIT_EI_EN    0
`define CFG_BIT_OE_N     1
`define CFG_BIT_CLK_INV  2
`define CFG_BIT_SERIAL   3
`define CFG_BIT_SWAP     4
`define CFG_BIT_EXT_CLK  5
`define CFG_BIT_AUTO_DIV 6
`define PKT_LEN          188
`define TEI_BYTE         1
`define TEI_BIT          7
`define DIV_DEFAULT      8'h03
`endif

// ===== rtl/tsout_pkg.sv
// types for the transport packet output port
package tsout_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01,
    ST_GAP  = 2'b11
  } out_state_t;
endpackage

// ===== rtl/byte_fifo.sv
// valid/ready fifo held in flip-flops
`timescale 1ns/1ps
module byte_fifo
#(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
)
(
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];   // storage
  logic [AW-1:0]    wr_ff;            // write index
  logic [AW-1:0]    rd_ff;            // read index
  logic [AW:0]      cnt_ff;           // fill level
  logic             push;
  logic             pop;

  // full at DEPTH entries; the level is one bit wider than the index
  assign in_ready  = (cnt_ff < (AW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign out_data  = mem_ff[rd_ff];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // storage write
  always_ff @(posedge clk)
  begin
    if (push)
      mem_ff[wr_ff] <= in_data;
  end

  // indices and level
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      if (push)
        wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
      if (pop)
        rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // byte_fifo

// ===== rtl/tsout_port.sv
// transport packet output port: fifo, pacing, pin timing and config register
//
// Contract
// - packet leaves as 188 consecutive clock bytes; an empty fifo in mid-packet ends the packet early and the port goes to the gap
// - enable bit set forces error indicator on bad packets
// - enable bit clear passes error indicator unchanged
// - pins driven only while output enable bit low; the clock pin has no enable and is always driven
// - sync byte moves at most one period
// - output clock runs continuously after symbol lock; the pin is held low while the receiver's own clock is selected
// - invert one: change on falling, sample rising
// - data lines held low between packets
// - start flag high on first byte only
// - valid flag high first through last byte
// - error flag low whole bad packet
// - serial data on bit seven if swapped
// - byte parallel or bit serial selectable
// - clock rate chosen from transmission parameters
// - receiver may supply its own clock
`timescale 1ns/1ps
`include "tsout_defines.svh"
module tsout_port
  import tsout_pkg::*;
#(
  parameter int FIFO_DEPTH = 16,
  parameter int GAP_CYCLES = 16
)
(
  input  wire logic       CLK,
  input  wire logic       RESET,
  input  wire logic [7:0] IN_BYTE,         // decoded byte from descrambler
  input  wire logic       IN_FIRST,        // first byte of packet
  input  wire logic       IN_BAD,          // packet is uncorrectable
  input  wire logic       IN_VALID,
  output logic            IN_READY,
  input  wire logic       SYMBOL_LOCK,     // symbol lock from the demodulator
  input  wire logic [7:0] RATE_DIV,        // half period chosen from mode parameters
  input  wire logic       EXT_CLOCK,       // clock supplied by the receiver
  input  wire logic [7:0] REG_ADDR,        // register address
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_WRITE,       // write strobe
  output logic      [7:0] REG_RDATA,
  output logic      [7:0] PACKET_BYTE_OUT,
  output logic      [7:0] PACKET_BYTE_OE,
  output logic            STREAM_OUT_CLOCK,
  output logic            PACKET_START_FLAG,
  output logic            PACKET_VALID_FLAG,
  output logic            BLOCK_ERROR_N,
  output logic            FLAGS_OE
);
  logic [7:0]  output_config_ff;        // configuration register
  logic [7:0]  div_cnt_ff;              // internal clock divider
  logic        int_clk_ff;              // internal output clock level
  logic        lock_s1_ff, lock_s2_ff;  // lock synchroniser
  logic        ext_s1_ff, ext_s2_ff;    // receiver clock synchroniser
  logic        ext_d_ff;                // previous receiver clock level
  logic        rise_tick, fall_tick;    // output clock edges
  logic        launch;                  // edge on which outputs change
  out_state_t  state_ff;
  logic [7:0]  byte_cnt_ff;             // byte index in packet
  logic [2:0]  bit_cnt_ff;              // bit index in serial mode
  logic [7:0]  gap_cnt_ff;              // gap length counter
  logic        bad_ff;                  // packet error latched at start
  logic [9:0]  fifo_in, fifo_out;
  logic        fifo_valid, fifo_pop;
  logic [7:0]  cur_byte;                // byte after error marking
  logic        ei_en, oe_n, inv, serial, swap, ext, auto_div;
  logic [7:0]  half_period;
  logic [7:0]  hold_ff;                 // byte being shifted out in serial mode
  logic [7:0]  head_idx;                // packet index of the byte at fifo head
  logic        head_bad;                // error state of the packet at fifo head
  logic        serial_bit;              // next bit for the serial lane

  assign ei_en    = output_config_ff[`CFG_BIT_EI_EN];
  assign oe_n     = output_config_ff[`CFG_BIT_OE_N];
  assign inv      = output_config_ff[`CFG_BIT_CLK_INV];
  assign serial   = output_config_ff[`CFG_BIT_SERIAL];
  assign swap     = output_config_ff[`CFG_BIT_SWAP];
  assign ext      = output_config_ff[`CFG_BIT_EXT_CLK];
  assign auto_div = output_config_ff[`CFG_BIT_AUTO_DIV];

  // rate from mode parameters, fallback when auto is off
  assign half_period = (auto_div && RATE_DIV != 8'h00) ? RATE_DIV : `DIV_DEFAULT;

  // register write port
  always_ff @(posedge CLK)
  begin
    if (RESET)
      output_config_ff <= `CFG_RESET;
    else if (REG_WRITE && REG_ADDR == `CFG_OFFSET)
      output_config_ff <= REG_WDATA;
  end

  // register read: unmapped reads zero
  always_ff @(posedge CLK)
  begin
    if (RESET)
      REG_RDATA <= 8'h00;
    else
      REG_RDATA <= (REG_ADDR == `CFG_OFFSET) ? output_config_ff : 8'h00;
  end

  // synchronisers for asynchronous inputs
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      lock_s1_ff <= 1'b0;
      lock_s2_ff <= 1'b0;
      ext_s1_ff  <= 1'b0;
      ext_s2_ff  <= 1'b0;
      ext_d_ff   <= 1'b0;
    end
    else
    begin
      lock_s1_ff <= SYMBOL_LOCK;
      lock_s2_ff <= lock_s1_ff;
      ext_s1_ff  <= EXT_CLOCK;
      ext_s2_ff  <= ext_s1_ff;
      ext_d_ff   <= ext_s2_ff;
    end
  end

  // free-running divider once locked, never gated per packet
  always_ff @(posedge CLK)
  begin
    if (RESET || !lock_s2_ff)
    begin
      div_cnt_ff <= 8'h00;
      int_clk_ff <= 1'b0;
    end
    else if (div_cnt_ff >= half_period - 8'h01)
    begin
      div_cnt_ff <= 8'h00;
      int_clk_ff <= ~int_clk_ff;
    end
    else
      div_cnt_ff <= div_cnt_ff + 8'h01;
  end

  // edge ticks: internal divider or receiver's clock
  always_comb
  begin
    if (ext)
    begin
      rise_tick = ext_s2_ff && !ext_d_ff;
      fall_tick = !ext_s2_ff && ext_d_ff;
    end
    else
    begin
      rise_tick = lock_s2_ff && !int_clk_ff && (div_cnt_ff >= half_period - 8'h01);
      fall_tick = lock_s2_ff && int_clk_ff && (div_cnt_ff >= half_period - 8'h01);
    end
  end

  // outputs launch on the edge opposite to the sampling one
  assign launch = inv ? fall_tick : rise_tick;

  // clock pin mirrors the internal clock, held low while the receiver's clock is selected
  always_ff @(posedge CLK)
  begin
    if (RESET)
      STREAM_OUT_CLOCK <= 1'b0;
    else
      STREAM_OUT_CLOCK <= ext ? 1'b0 : int_clk_ff;
  end

  assign fifo_in = {IN_BAD, IN_FIRST, IN_BYTE};

  byte_fifo #(.WIDTH(10), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (CLK),
    .reset     (RESET),
    .in_data   (fifo_in),
    .in_valid  (IN_VALID),
    .in_ready  (IN_READY),
    .out_data  (fifo_out),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  // pop one byte per byte slot: a packet opens only on a first byte and
  // never runs past its last byte, so the next packet keeps its own start
  assign fifo_pop = launch && fifo_valid && !oe_n &&
                    ((state_ff == ST_IDLE) ? fifo_out[8] :
                     ((state_ff == ST_SEND) && byte_cnt_ff != 8'(`PKT_LEN - 1) &&
                      (!serial || bit_cnt_ff == 3'd0)));

  // pins show byte_cnt_ff, so the fifo head is one byte further on
  assign head_idx = (state_ff == ST_SEND) ? byte_cnt_ff + 8'h01 : 8'h00;
  assign head_bad = (state_ff == ST_SEND) ? bad_ff : fifo_out[9];

  // set error indicator of bad packets when enabled
  always_comb
  begin
    cur_byte = fifo_out[7:0];
    if (head_idx == 8'(`TEI_BYTE) && ei_en && head_bad)
      cur_byte[`TEI_BIT] = 1'b1;
    // enable clear: header passes through untouched
  end

  // held copy of the popped byte: the fifo head moves on at once
  always_ff @(posedge CLK)
  begin
    if (RESET)
      hold_ff <= 8'h00;
    else if (fifo_pop)
      hold_ff <= cur_byte;
  end

  // msb first: bit seven at the pop, then the held byte downwards
  assign serial_bit = fifo_pop ? cur_byte[7] : hold_ff[bit_cnt_ff - 3'd1];

  // packet sequencer
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      state_ff    <= ST_IDLE;
      byte_cnt_ff <= 8'h00;
      bit_cnt_ff  <= 3'd0;
      gap_cnt_ff  <= 8'h00;
      bad_ff      <= 1'b0;
    end
    else if (launch)
    begin
      case (state_ff)
        ST_IDLE:
          if (fifo_pop)
          begin
            state_ff    <= ST_SEND;
            byte_cnt_ff <= 8'h00;
            bad_ff      <= fifo_out[9];
            bit_cnt_ff  <= serial ? 3'd7 : 3'd0;
          end
        ST_SEND:
          if (serial && bit_cnt_ff != 3'd0)
            bit_cnt_ff <= bit_cnt_ff - 3'd1;
          else if (!fifo_valid) // underrun: stream aborts to gap
          begin
            state_ff   <= ST_GAP;
            gap_cnt_ff <= 8'h00;
          end
          else if (byte_cnt_ff == 8'(`PKT_LEN - 1))
          begin
            state_ff   <= ST_GAP;
            gap_cnt_ff <= 8'h00;
          end
          else
          begin
            byte_cnt_ff <= byte_cnt_ff + 8'h01;
            bit_cnt_ff  <= serial ? 3'd7 : 3'd0;
          end
        ST_GAP:
          if (gap_cnt_ff >= 8'(GAP_CYCLES - 1))
            state_ff <= ST_IDLE;
          else
            gap_cnt_ff <= gap_cnt_ff + 8'h01;
        default:
          state_ff <= ST_IDLE;
      endcase
    end
  end

  // pin outputs, updated on the launch edge only
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      PACKET_BYTE_OUT   <= 8'h00;
      PACKET_START_FLAG <= 1'b0;
      PACKET_VALID_FLAG <= 1'b0;
      BLOCK_ERROR_N     <= 1'b1;
    end
    else if (launch)
    begin
      if (fifo_pop || (state_ff == ST_SEND && serial && bit_cnt_ff != 3'd0))
      begin
        PACKET_START_FLAG <= (state_ff != ST_SEND);
        PACKET_VALID_FLAG <= 1'b1;
        BLOCK_ERROR_N     <= (state_ff != ST_SEND) ? !fifo_out[9] : !bad_ff;
        if (serial)
        begin
          PACKET_BYTE_OUT <= 8'h00;
          if (swap)
            PACKET_BYTE_OUT[7] <= serial_bit;
          else
            PACKET_BYTE_OUT[0] <= serial_bit;
        end
        else
          PACKET_BYTE_OUT <= cur_byte;
      end
      else
      begin
        PACKET_BYTE_OUT   <= 8'h00;
        PACKET_START_FLAG <= 1'b0;
        PACKET_VALID_FLAG <= 1'b0;
        BLOCK_ERROR_N     <= 1'b1;
      end
    end
  end

  // pin drivers enabled only while enable bit low
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      PACKET_BYTE_OE <= 8'h00;
      FLAGS_OE       <= 1'b0;
    end
    else
    begin
      PACKET_BYTE_OE <= {8{!oe_n}};
      FLAGS_OE       <= !oe_n;
    end
  end

  // checks
  sequence start_seq;
    PACKET_START_FLAG && PACKET_VALID_FLAG;
  endsequence

  start_valid_a: assert property (@(posedge CLK) disable iff (RESET)
    PACKET_START_FLAG |-> PACKET_VALID_FLAG)
    else $error("start without valid");
  gap_low_a: assert property (@(posedge CLK) disable iff (RESET)
    !PACKET_VALID_FLAG |-> PACKET_BYTE_OUT == 8'h00)
    else $error("data not low in gap");
  err_in_pkt_a: assert property (@(posedge CLK) disable iff (RESET)
    !BLOCK_ERROR_N |-> PACKET_VALID_FLAG)
    else $error("error flag outside packet");
  oe_off_a: assert property (@(posedge CLK) disable iff (RESET)
    oe_n && $past(oe_n) |-> FLAGS_OE == 1'b0)
    else $error("pins driven while disabled");
  data_oe_off_a: assert property (@(posedge CLK) disable iff (RESET)
    oe_n && $past(oe_n) |-> PACKET_BYTE_OE == 8'h00)
    else $error("data pins driven while disabled");
  count_bound_a: assert property (@(posedge CLK) disable iff (RESET)
    byte_cnt_ff < 8'(`PKT_LEN))
    else $error("byte index beyond packet");
  start_once_a: assert property (@(posedge CLK) disable iff (RESET)
    launch ##0 start_seq |=> !PACKET_START_FLAG)
    else $error("start flag stuck");
  swap_lane_a: assert property (@(posedge CLK) disable iff (RESET)
    serial && $past(serial) && PACKET_VALID_FLAG && $past(swap) && swap
      |-> PACKET_BYTE_OUT[6:0] == 7'h00)
    else $error("serial data on wrong lane");
  lane_low_a: assert property (@(posedge CLK) disable iff (RESET)
    serial && $past(serial) && PACKET_VALID_FLAG && !$past(swap) && !swap
      |-> PACKET_BYTE_OUT[7:1] == 7'h00)
    else $error("serial data off the low lane");

  // parallel slot that carries the header byte of a bad packet
  sequence tei_slot_seq;
    launch && fifo_pop && !serial && ei_en && head_bad && head_idx == 8'(`TEI_BYTE);
  endsequence

  tei_force_a: assert property (@(posedge CLK) disable iff (RESET)
    tei_slot_seq |=> PACKET_BYTE_OUT[`TEI_BIT])
    else $error("error indicator not forced");
endmodule // tsout_port

// ===== bench/stream_rx.sv
// downstream demultiplexer model: samples the stream pins and collects packets
`timescale 1ns/1ps
module stream_rx
(
  input  wire logic       clk,
  input  wire logic [7:0] cfg,      // mirror of the output config register
  input  wire logic       ext_run,  // receiver supplies its own clock
  input  wire logic [7:0] data,
  input  wire logic       out_clk,
  input  wire logic       start,
  input  wire logic       valid,
  input  wire logic       err_n,
  output logic            ext_clk
);
  logic [7:0] rx_q[$];      // bytes of the latest packet
  logic [7:0] sh;           // serial assembly, first bit ends up on top
  logic       sclk;         // clock the receiver samples with
  logic       pclk = 1'b0;  // last seen level of that clock
  logic       pval = 1'b0;  // last sampled valid flag
  int         nbit, n_pkt, n_start, n_err, gap_bad, slot, s0, span;
  // own clock only while enabled, otherwise it stands low
  initial ext_clk = 1'b0;
  always #62.5 ext_clk = ext_run ? ~ext_clk : 1'b0;
  assign sclk = cfg[5] ? ext_clk : out_clk;
  // sample on the edge opposite the launch edge
  always @(negedge clk)
  begin
    if (sclk !== pclk && sclk === cfg[2])
    begin
      slot++;
      // a start restarts collection, so a stray start shortens the packet
      if (start)
      begin
        rx_q.delete();
        nbit = 0;
        n_start++;
        span = slot - s0;
        s0 = slot;
      end
      if (valid)
      begin
        n_err += !err_n;
        sh = {sh[6:0], cfg[4] ? data[7] : data[0]};
        nbit++;
        if (!cfg[3])
          rx_q.push_back(data);
        else if (nbit % 8 == 0)
          rx_q.push_back(sh);
      end
      else if (data !== 8'h00 || start)
        gap_bad++;
      if (pval && !valid)
        n_pkt++;
      pval = valid;
    end
    pclk = sclk;
  end
endmodule // stream_rx

// ===== bench/testbench.sv
// self-checking bench for the transport packet output port
`timescale 1ns/1ps
module testbench;
  localparam int GAP = 16;  // gap slots handed to the design
  logic       clk = 1'b0, rst = 1'b1, ifst = 1'b0, ibad = 1'b0, iv = 1'b0;
  logic       lock = 1'b0, wr = 1'b0, ext_run = 1'b0;
  logic [7:0] ib = 8'h00, div = 8'h03, ra = 8'h00, wd = 8'h00, cfg = 8'h45;
  logic       ird, soc, pst, pv, pe_n, foe, ext;
  logic [7:0] rd, pb, poe;
  int         n_fail, compares, t;
  always #5 clk = ~clk;
  tsout_port #(.FIFO_DEPTH(16), .GAP_CYCLES(GAP)) tsout_port_inst
  (
    .CLK(clk), .RESET(rst), .IN_BYTE(ib), .IN_FIRST(ifst), .IN_BAD(ibad),
    .IN_VALID(iv), .IN_READY(ird), .SYMBOL_LOCK(lock), .RATE_DIV(div),
    .EXT_CLOCK(ext), .REG_ADDR(ra), .REG_WDATA(wd), .REG_WRITE(wr),
    .REG_RDATA(rd), .PACKET_BYTE_OUT(pb), .PACKET_BYTE_OE(poe),
    .STREAM_OUT_CLOCK(soc), .PACKET_START_FLAG(pst), .PACKET_VALID_FLAG(pv),
    .BLOCK_ERROR_N(pe_n), .FLAGS_OE(foe)
  );
  stream_rx stream_rx_inst
  (
    .clk(clk), .cfg(cfg), .ext_run(ext_run), .data(pb), .out_clk(soc),
    .start(pst), .valid(pv), .err_n(pe_n), .ext_clk(ext)
  );
  // one comparison, counted
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // register write: strobe for one edge, config changes only between packets
  task automatic reg_wr(input logic [7:0] v);
    ra = 8'h8A;
    wd = v;
    wr = 1'b1;
    @(negedge clk) wr = 1'b0;
    cfg = v;
  endtask
  // register read: data is registered one edge after the address
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
    ra = a;
    @(negedge clk);
    check(rd, exp);
  endtask
  // payload pattern; byte one carries the error indicator on top
  function automatic logic [7:0] byte_of(input int i, input logic tei);
    if (i == 0)
      return 8'h47;
    if (i == 1)
      return {tei, 7'h1F};
    return i[7:0] ^ 8'h5A;
  endfunction
  // hand one packet to the fifo; a full fifo holds us back
  task automatic send(input logic bad, input logic tei);
    for (int i = 0; i < 188; i++)
    begin
      ib = byte_of(i, tei);
      ifst = (i == 0);
      ibad = bad;
      iv = 1'b1;
      t = 0;
      // ready is settled at the falling edge; the byte goes in at the next rise
      while (ird !== 1'b1 && t < 5000)
      begin
        @(negedge clk);
        t++;
      end
      if (t >= 5000)
      begin
        n_fail++;
        conclude();
      end
      @(negedge clk);
    end
    iv = 1'b0;
  endtask
  // k packets back to back, then check what the receiver collected
  task automatic run(input logic bad, input logic tei, input int k);
    int slots;
    slots = cfg[3] ? 1504 : 188;
    stream_rx_inst.n_pkt = 0;
    stream_rx_inst.n_start = 0;
    stream_rx_inst.n_err = 0;
    repeat (k) send(bad, tei);
    t = 0;
    while (stream_rx_inst.n_pkt < k && t < 40000)
    begin
      @(negedge clk);
      t++;
    end
    if (t >= 40000)
    begin
      n_fail++;
      conclude();
    end
    check(stream_rx_inst.rx_q.size(), 188);
    for (int i = 0; i < stream_rx_inst.rx_q.size(); i++)
      check(stream_rx_inst.rx_q[i], byte_of(i, tei | (bad & cfg[0])));
    check(stream_rx_inst.n_start, k);
    check(stream_rx_inst.n_err, bad ? k * slots : 0);
    if (k == 2)
      check(stream_rx_inst.span >= 187 + GAP && stream_rx_inst.span <= 189 + GAP, 1);
  endtask
  // count level changes of the output clock over n cycles
  task automatic toggles(input int n);
    logic p;
    p = soc;
    t = 0;
    repeat (n)
    begin
      @(negedge clk);
      t += (soc !== p);
      p = soc;
    end
  endtask
  initial
  begin
    repeat (3) @(negedge clk);
    rst = 1'b0;
    reg_rd(8'h8A, 8'h45);
    reg_rd(8'h10, 8'h00);
    // no lock, no clock; with lock a steady clock at the chosen rate
    toggles(60);
    check(t, 0);
    lock = 1'b1;
    div = 8'h05;
    repeat (10) @(negedge clk);
    toggles(60);
    check(t >= 11 && t <= 13, 1);
    reg_wr(8'h05);
    toggles(60);
    check(t >= 19 && t <= 21, 1);
    div = 8'h03;
    reg_wr(8'h47);
    repeat (4) @(negedge clk);
    check({poe, foe}, 9'h000);
    reg_wr(8'h45);
    repeat (4) @(negedge clk);
    check({poe, foe}, 9'h1FF);
    run(1'b0, 1'b0, 2);
    run(1'b1, 1'b0, 1);
    reg_wr(8'h44);
    run(1'b1, 1'b0, 1);
    run(1'b1, 1'b1, 1);
    reg_wr(8'h41);
    run(1'b0, 1'b1, 1);
    reg_wr(8'h4D);
    run(1'b1, 1'b0, 1);
    reg_wr(8'h5D);
    run(1'b0, 1'b0, 1);
    ext_run = 1'b1;
    reg_wr(8'h65);
    run(1'b0, 1'b0, 1);
    ext_run = 1'b0;
    check(stream_rx_inst.gap_bad, 0);
    conclude();
  end
endmodule // testbench
